// [rtl/speed_sensor_fault_supervisor.sv]
// fault supervisor for encoder tracks and proximity switch frequency deviation
// Function
// - report 10260 for invalid inverted A, 10261 for invalid inverted B.
// - report 10263 when B track lies outside its voltage window.
// - report 10264 when S track leaves its min/max window.
// - report 10266 when index track or inverse is stuck high.
// - report 10267 when index track or inverse is stuck low.
// - report 10268 when neither A nor B carries a plausible signal.
// - report 10269 when inverted A and B carry no plausible signal.
// - open circuit lights fault lamp, drops outputs, posts an error.
// - open-circuit report refreshes continuously until the fault disappears.
// - open-circuit report names which of pairs A, B, Z are implausible.
// - after open circuit or error 6000 clears, outputs stay off until restart.
// - long large proximity frequency difference lights lamp and raises a warning.
// - warning and lamp clear once both switches deliver valid signals and the deviation has dropped.
// - during the warning, range monitoring counts as violated.
// - persistent deviation without valid signals latches error 6000, outputs off.
// - error 6000 clears on valid signals on both switches or start falling edge.
// - report 10256 when both pnp/pnp proximity switches are inactive.
`timescale 1ns/1ps
`default_nettype none
module speed_sensor_fault_supervisor
   import sensor_fault_pkg::*;
#(
   parameter int ESCALATE_LIMIT = ESCALATE_CYCLES,
   parameter int N_OUT          = NUM_OUTPUTS
) (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire enc_flags_t        encFlags,
   input  wire open_pairs_t       openPairs,
   input  wire prox_t             prox,
   input  wire logic              startInputTerminal,
   input  wire logic              startupOk,
   input  wire logic [N_OUT-1:0]  rangeOk,
   output logic [N_OUT-1:0]       outEnable,
   output logic                   faultLed,
   output logic [CODE_W-1:0]      errorCode,
   output logic                   errorValid,
   output open_pairs_t            openReport,
   output logic                   openActive,
   output logic                   freqWarning,
   output logic                   freqLatched,
   output logic                   rangeViolated
);
   typedef enum logic [1:0] {RUN, BLOCKED} out_state_t;

   out_state_t        outState;
   logic [CODE_W-1:0] encCode;
   logic              encAny;
   logic              pnpBoth;
   logic              openNow;
   logic              bothValid;
   logic              escalate;
   logic              startPrev;
   logic              startFall;
   logic              shutdown;
   logic [CODE_W-1:0] next_errorCode;

   // both switches inactive only matters in the pnp/pnp wiring
   assign pnpBoth   = prox.pnpPnp && !prox.activeA && !prox.activeB;
   assign openNow   = openPairs.pairA || openPairs.pairB || openPairs.pairZ;
   assign bothValid = prox.validA && prox.validB;
   assign startFall = startPrev && !startInputTerminal;

   fault_code_encoder u_codes (
      .flags   (encFlags),
      .pnpBoth (pnpBoth),
      .code    (encCode),
      .any     (encAny)
   );

   // warning must stand unbroken, without valid signals, for the whole limit
   persist_counter #(
      .LIMIT (ESCALATE_LIMIT)
   ) u_escalate (
      .sys_clk (sys_clk),
      .rst     (rst),
      .cond    (freqWarning && !bothValid && !freqLatched),
      .expired (escalate)
   );

   // start terminal history for falling edge detection
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         startPrev <= 1'b0;
      end else begin
         startPrev <= startInputTerminal;
      end
   end

   // open-circuit report follows the live pair flags every cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         openReport <= '0;
         openActive <= 1'b0;
      end else begin
         openReport <= openPairs;
         openActive <= openNow;
      end
   end

   // non-latching warning: valid signals on both switches end it once the deviation has dropped
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         freqWarning <= 1'b0;
      end else if (prox.deviation) begin
         freqWarning <= 1'b1;
      end else if (bothValid) begin
         freqWarning <= 1'b0;
      end
   end

   // latched error; a new escalation wins over a clear in the same cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         freqLatched <= 1'b0;
      end else if (escalate) begin
         freqLatched <= 1'b1;
      end else if (bothValid || startFall) begin
         freqLatched <= 1'b0;
      end
   end

   // once shut down, outputs wait for the start-up conditions after the fault ends
   assign shutdown = openActive || freqLatched;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         outState <= BLOCKED;
      end else begin
         case (outState)
            RUN:     if (shutdown) outState <= BLOCKED;
            BLOCKED: if (!shutdown && startupOk) outState <= RUN;
            default: outState <= BLOCKED;
         endcase
      end
   end

   // latched error outranks the pnp both-inactive and track codes
   always_comb begin
      next_errorCode = encCode;
      if (freqLatched) next_errorCode = CODE_FREQ_LATCH;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         errorCode  <= CODE_NONE;
         errorValid <= 1'b0;
      end else begin
         errorCode  <= next_errorCode;
         // live open-circuit flag so the error posts together with openActive
         errorValid <= encAny || freqLatched || openNow;
      end
   end

   // warning forces range monitoring to count as violated on every output
   assign rangeViolated = freqWarning;
   assign faultLed = openActive || freqWarning || freqLatched;
   always_comb begin
      for (int i = 0; i < N_OUT; i++) begin
         outEnable[i] = (outState == RUN) && !shutdown && !freqWarning && rangeOk[i];
      end
   end
endmodule : speed_sensor_fault_supervisor
`default_nettype wire

// [rtl/sensor_fault_pkg.sv]
// shared constants and carrier types for the speed sensor fault supervisor
package sensor_fault_pkg;
   localparam int CODE_W = 14;
   localparam logic [CODE_W-1:0] CODE_NONE        = 14'h0000;
   localparam logic [CODE_W-1:0] CODE_INV_A       = 14'h2814; // 10260
   localparam logic [CODE_W-1:0] CODE_INV_B       = 14'h2815; // 10261
   localparam logic [CODE_W-1:0] CODE_B_VOLT      = 14'h2817; // 10263
   localparam logic [CODE_W-1:0] CODE_S_VOLT      = 14'h2818; // 10264
   localparam logic [CODE_W-1:0] CODE_Z_HIGH      = 14'h281A; // 10266
   localparam logic [CODE_W-1:0] CODE_Z_LOW       = 14'h281B; // 10267
   localparam logic [CODE_W-1:0] CODE_AB_NONE     = 14'h281C; // 10268
   localparam logic [CODE_W-1:0] CODE_NAB_NONE    = 14'h281D; // 10269
   localparam logic [CODE_W-1:0] CODE_PNP_BOTH    = 14'h2810; // 10256
   localparam logic [CODE_W-1:0] CODE_FREQ_LATCH  = 14'h1770; // 6000
   // escalation persistence time in ms and its cycle count at 40 MHz
   localparam int CLK_HZ          = 40_000_000;
   localparam int ESCALATE_MS     = 2000;
   localparam int ESCALATE_CYCLES = (CLK_HZ / 1000) * ESCALATE_MS;
   localparam int NUM_OUTPUTS     = 4;

   // encoder front-end comparator flags, one bit per fault
   typedef struct packed {
      logic invA;       // invalid signal on inverted A
      logic invB;       // invalid signal on inverted B
      logic bVolt;      // B outside voltage window
      logic sVolt;      // S outside min/max window
      logic zHigh;      // index stuck high
      logic zLow;       // index stuck low
      logic abNone;     // no plausible A/B
      logic nabNone;    // no plausible inverted A/B
   } enc_flags_t;

   // open-circuit plausibility per track pair
   typedef struct packed {
      logic pairA;
      logic pairB;
      logic pairZ;
   } open_pairs_t;

   // proximity switch status
   typedef struct packed {
      logic pnpPnp;     // wiring is pnp/pnp
      logic activeA;
      logic activeB;
      logic deviation;  // frequencies differ too much for too long
      logic validA;     // valid signal above standstill on A
      logic validB;     // valid signal above standstill on B
   } prox_t;
endpackage : sensor_fault_pkg

// [rtl/fault_code_encoder.sv]
// priority encoder from encoder fault flags to numeric error codes
`timescale 1ns/1ps
`default_nettype none
module fault_code_encoder
   import sensor_fault_pkg::*;
(
   input  wire enc_flags_t            flags,
   input  wire logic                  pnpBoth,
   output logic [CODE_W-1:0]          code,
   output logic                       any
);
   // lowest code number wins when several faults stand together
   always_comb begin
      code = CODE_NONE;
      if (pnpBoth)            code = CODE_PNP_BOTH;
      else if (flags.invA)    code = CODE_INV_A;
      else if (flags.invB)    code = CODE_INV_B;
      else if (flags.bVolt)   code = CODE_B_VOLT;
      else if (flags.sVolt)   code = CODE_S_VOLT;
      else if (flags.zHigh)   code = CODE_Z_HIGH;
      else if (flags.zLow)    code = CODE_Z_LOW;
      else if (flags.abNone)  code = CODE_AB_NONE;
      else if (flags.nabNone) code = CODE_NAB_NONE;
      any = (code != CODE_NONE);
   end
endmodule : fault_code_encoder
`default_nettype wire

// [rtl/persist_counter.sv]
// saturating persistence counter that flags when a condition holds long enough
`timescale 1ns/1ps
`default_nettype none
module persist_counter #(
   parameter int LIMIT = 4
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic cond,
   output logic      expired
);
   localparam int CW = $clog2(LIMIT + 1);
   localparam logic [CW-1:0] LIM = CW'(LIMIT);
   logic [CW-1:0] count;

   // restarts whenever the condition drops, so only unbroken spans count
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         count <= '0;
      end else if (!cond) begin
         count <= '0;
      end else if (count != LIM) begin
         count <= count + CW'(1);
      end
   end

   assign expired = cond && (count == LIM);
endmodule : persist_counter
`default_nettype wire

// [tb/sensor_fault_chk.sv]
// port-level assertions for the speed sensor fault supervisor
`timescale 1ns/1ps
`default_nettype none
module sensor_fault_chk
   import sensor_fault_pkg::*;
#(
   parameter int ESCALATE_LIMIT = 8,
   parameter int N_OUT          = 4
) (
   input wire logic              sys_clk,
   input wire logic              rst,
   input wire enc_flags_t        encFlags,
   input wire open_pairs_t       openPairs,
   input wire prox_t             prox,
   input wire logic              startupOk,
   input wire logic [N_OUT-1:0]  outEnable,
   input wire logic              faultLed,
   input wire logic [CODE_W-1:0] errorCode,
   input wire logic              errorValid,
   input wire open_pairs_t       openReport,
   input wire logic              openActive,
   input wire logic              freqWarning,
   input wire logic              freqLatched,
   input wire logic              rangeViolated
);
   int   warnRun;
   logic bothOk;
   logic pnpBoth;
   assign bothOk = prox.validA && prox.validB;
   assign pnpBoth = prox.pnpPnp && !prox.activeA && !prox.activeB;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // age of an unresolved warning; margin of two cycles for the latch register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) warnRun <= 0;
      else warnRun <= (freqWarning && !bothOk) ? warnRun + 1 : 0;
   end
   AST_OPEN_SET: assert property (|openPairs |=> openActive && errorValid)
      else $error("open circuit not flagged");
   AST_OPEN_RPT: assert property (1 |=> openReport == $past(openPairs))
      else $error("open report stale");
   AST_LED: assert property (faultLed == (openActive || freqWarning || freqLatched))
      else $error("fault lamp wrong");
   AST_OFF: assert property (openActive || freqWarning || freqLatched |-> outEnable == '0)
      else $error("outputs on during fault");
   AST_RANGE: assert property (rangeViolated == freqWarning)
      else $error("range violation wrong");
   AST_WARN_SET: assert property (prox.deviation |=> freqWarning)
      else $error("warning missing");
   AST_WARN_CLR: assert property (bothOk && !prox.deviation |=> !freqWarning)
      else $error("warning stuck");
   AST_ESC: assert property (warnRun == ESCALATE_LIMIT + 3 |-> freqLatched ##[0:1]
      errorCode == CODE_FREQ_LATCH)
      else $error("no escalation");
   AST_LATCH_CLR: assert property (freqLatched && bothOk |=> !freqLatched)
      else $error("latched error stuck");
   AST_RESTART: assert property ((openActive || freqLatched) ##1 !startupOk |-> outEnable == '0)
      else $error("outputs back without restart");
   AST_CODE: assert property (encFlags.invA && !pnpBoth && !freqLatched |=>
      errorCode == CODE_INV_A || freqLatched)
      else $error("inverted A code wrong");
endmodule : sensor_fault_chk
bind speed_sensor_fault_supervisor sensor_fault_chk #(.ESCALATE_LIMIT(ESCALATE_LIMIT),
   .N_OUT(N_OUT)) i_sensor_fault_chk (.*);
`default_nettype wire

// [tb/prox_pair_model.sv]
// behavioural pair of proximity switches on the far side
`timescale 1ns/1ps
`default_nettype none
module prox_pair_model
   import sensor_fault_pkg::*;
(
   input  wire logic pnpWiring,
   input  wire logic sys_clk,
   input  wire logic runA,
   input  wire logic runB,
   input  wire logic mismatch,
   output var prox_t prox
);
   initial prox = '0;
   // running switches pulse in antiphase so one is always active; a stopped one rests low
   always @(posedge sys_clk) begin
      prox <= '{pnpWiring, runA && !prox.activeA, runB && (runA ? prox.activeA : !prox.activeB),
         mismatch, runA, runB};
   end
endmodule : prox_pair_model
`default_nettype wire

// [tb/speed_sensor_fault_supervisor_tb.sv]
// self-checking bench for the speed sensor fault supervisor
`timescale 1ns/1ps
`default_nettype none
module speed_sensor_fault_supervisor_tb import sensor_fault_pkg::*;;
   localparam int LIM = 8;
   localparam logic [CODE_W-1:0] CODES [8] = '{CODE_INV_A, CODE_INV_B, CODE_B_VOLT,
      CODE_S_VOLT, CODE_Z_HIGH, CODE_Z_LOW, CODE_AB_NONE, CODE_NAB_NONE};
   logic sys_clk = 0, rst = 1, startIn = 1, startupOk = 0;
   logic pnpWiring = 0, runA = 1, runB = 1, mismatch = 0;
   logic [3:0] rangeOk = 4'hF, outEnable;
   logic [CODE_W-1:0] errorCode;
   logic faultLed, errorValid, openActive, freqWarning, freqLatched, rangeViolated;
   enc_flags_t encFlags = '0;
   open_pairs_t openPairs = '0, openReport;
   prox_t prox;
   int mismatches = 0, check_count = 0;
   initial forever #12.5 sys_clk = ~sys_clk;
   prox_pair_model i_prox_pair_model (.pnpWiring, .sys_clk, .runA, .runB, .mismatch, .prox);
   speed_sensor_fault_supervisor #(.ESCALATE_LIMIT(LIM), .N_OUT(4)) i_speed_sensor_fault_supervisor (
      .sys_clk, .rst, .encFlags, .openPairs, .prox, .startInputTerminal(startIn), .startupOk,
      .rangeOk, .outEnable, .faultLed, .errorCode, .errorValid, .openReport, .openActive,
      .freqWarning, .freqLatched, .rangeViolated);
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : step
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim;
      if (mismatches == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim
   // each fault flag alone, then all of them under the pnp both-inactive code
   task automatic t_codes;
      for (int i = 0; i < 8; i++) begin
         step(1);
         encFlags <= 8'h80 >> i;
         step(3);
         @(negedge sys_clk);
         chk(errorCode, CODES[i]);
      end
      step(1);
      {pnpWiring, runA, runB, encFlags} <= {3'b100, 8'hFF};
      step(4);
      @(negedge sys_clk);
      chk(errorCode, CODE_PNP_BOTH);
      step(1);
      {pnpWiring, runA, runB, encFlags} <= {3'b011, 8'h00};
   endtask : t_codes
   // open circuit: report follows the pairs, outputs wait for a restart
   task automatic t_open;
      step(1);
      {startupOk, rangeOk} <= {1'b1, 4'hA};
      step(3);
      {startupOk, openPairs} <= 4'b0101;
      step(3);
      @(negedge sys_clk);
      chk(openReport, 3'b101);
      chk({faultLed, errorValid, outEnable}, 6'h30);
      step(1);
      openPairs <= 3'b010;
      step(3);
      @(negedge sys_clk);
      chk(openReport, 3'b010);
      step(1);
      openPairs <= '0;
      step(4);
      @(negedge sys_clk);
      chk({faultLed, outEnable}, 5'h00);
      step(1);
      startupOk <= 1;
      step(4);
      @(negedge sys_clk);
      chk(outEnable, 4'hA);
   endtask : t_open
   // warning, escalation to the latched error and its clearing
   task automatic t_freq;
      int n;
      step(1);
      {runA, runB, mismatch} <= 3'b001;
      step(3);
      @(negedge sys_clk);
      chk({freqWarning, rangeViolated, faultLed, outEnable}, 7'h70);
      // sampled at falling edges, away from the edge that launches the latch
      for (n = 0; n < 40 && freqLatched !== 1'b1; n++) @(negedge sys_clk);
      if (n == 40) begin
         mismatches++;
         end_sim;
      end
      chk(n, LIM);
      step(2);
      @(negedge sys_clk);
      chk({errorCode, faultLed, outEnable}, {CODE_FREQ_LATCH, 5'h10});
      step(1);
      {startupOk, startIn, runA, runB} <= 4'b0011;
      step(3);
      @(negedge sys_clk);
      chk({freqLatched, freqWarning, outEnable}, 6'h10);
      step(1);
      mismatch <= 0;
      step(3);
      @(negedge sys_clk);
      chk({freqWarning, faultLed, outEnable}, 6'h00);
   endtask : t_freq
   initial begin
      step(4);
      rst <= 0;
      t_codes;
      t_open;
      t_freq;
      end_sim;
   end
endmodule : speed_sensor_fault_supervisor_tb
`default_nettype wire
